// ### rtl/mode_selector_regs.vh
`ifndef MODE_SELECTOR_REGS_VH
`define MODE_SELECTOR_REGS_VH

// ****************************************
// Clock and timing
// ****************************************
`define CLK_FREQ_HZ      10000000
`define CYCLES_PER_MS    (`CLK_FREQ_HZ / 1000)
`define HOLD_TIME_MS     2000
`define TIMEOUT_TIME_MS  10000
`define DEBOUNCE_TIME_MS 10
`define FLASH_TIME_MS    250
`define TMR_W            27

// ****************************************
// Operating modes, list order
// ****************************************
`define MODE_NORMAL      3'h0
`define MODE_HAND        3'h1
`define MODE_ALIGN       3'h2
`define MODE_BEAM        3'h3
`define MODE_DROP        3'h4
`define MODE_LAST        3'h4
`define MODE_COUNT       5

// ****************************************
// Signal quality bar
// ****************************************
`define LEVEL_W          4
`define GREEN_MIN_LEVEL  4'h3

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_IRQ_STATUS   8'h08
`define REG_IRQ_CLEAR    8'h0C
`define REG_IRQ_ENABLE   8'h10

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_LASER_BIT   0
`define CTRL_REARM_BIT   1
`define CTRL_RESET       1'h1
`define IRQ_W            5
`define IRQ_COMMIT_BIT   0
`define IRQ_TIMEOUT_BIT  1
`define IRQ_DROP_BIT     2
`define IRQ_SHUTOFF_BIT  3
`define IRQ_PEER_BIT     4
`define IRQ_ENABLE_RESET 5'h00

`endif

// ### rtl/button_debounce.v
`timescale 1ns/100ps
module button_debounce #(
  parameter         W     = 17,
  parameter [W-1:0] LIMIT = 17'h186A0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Button
  input  wire raw_i,
  output reg  clean_o
);

  reg [W-1:0] cnt_reg;

  // Change accepted only after the raw level held steady for LIMIT cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= {W{1'b0}};
      clean_o <= 1'b0;
    end else if (raw_i == clean_o) begin
      cnt_reg <= {W{1'b0}};
    end else if (cnt_reg == LIMIT - 1'b1) begin
      cnt_reg <= {W{1'b0}};
      clean_o <= raw_i;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule // button_debounce

// ### rtl/cycle_timer.v
`timescale 1ns/100ps
module cycle_timer #(
  parameter         W     = 27,
  parameter [W-1:0] LIMIT = 27'h0000010
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Control
  input  wire clr_i,
  input  wire run_i,
  output reg  done_o
);

  reg [W-1:0] cnt_reg;

  // Done stays high until cleared
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_reg <= {W{1'b0}};
      done_o  <= 1'b0;
    end else if (run_i && !done_o) begin
      if (cnt_reg == LIMIT - 1'b1)
        done_o <= 1'b1;
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule // cycle_timer

// ### rtl/mode_selector.v
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/100ps
`include "mode_selector_regs.vh"
module mode_selector #(
  parameter HOLD_CYCLES     = `HOLD_TIME_MS * `CYCLES_PER_MS,
  parameter TIMEOUT_CYCLES  = `TIMEOUT_TIME_MS * `CYCLES_PER_MS,
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_TIME_MS * `CYCLES_PER_MS,
  parameter FLASH_CYCLES    = `FLASH_TIME_MS * `CYCLES_PER_MS
) (
  // Clock and reset
  input  wire                clk_i,
  input  wire                rst_i,
  // Wishbone slave
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [7:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o,
  output reg                 irq_o,
  // Operator panel
  input  wire                mode_button_i,
  output reg  [4:0]          mode_led_o,
  output reg                 drop_red_o,
  output reg  [`LEVEL_W-1:0] bar_level_o,
  // Optical link
  input  wire [`LEVEL_W-1:0] rx_level_i,
  input  wire                link_ok_i,
  output reg                 tx_enable_o,
  output reg                 beam_on_o,
  // Opposing unit
  input  wire                peer_hand_i,
  input  wire                peer_align_req_i,
  input  wire [`LEVEL_W-1:0] peer_level_i,
  output reg                 peer_align_cmd_o,
  output reg  [`LEVEL_W-1:0] peer_level_o
);

  // ****************************************
  // Selector states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PICK = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  reg  [1:0]        state_reg;
  reg  [2:0]        active_reg;
  reg  [2:0]        pending_reg;
  reg               btn_d_reg;
  reg               flash_reg;
  reg               commit_reg;
  reg               timeout_reg;
  reg               laser_fit_reg;
  reg  [`IRQ_W-1:0] irq_status_reg;
  reg  [`IRQ_W-1:0] irq_status_next;
  reg  [`IRQ_W-1:0] irq_enable_reg;
  reg  [4:0]        led_next;
  reg               tx_next;
  wire              btn;
  wire              long_hit;
  wire              timeout_hit;
  wire              flash_tick;
  wire              btn_up;
  wire              wb_req;
  wire              wb_wr;
  wire              rearm;
  wire [`IRQ_W-1:0] irq_clear;
  integer           i;

  // Skips the beam mode on units without a pointer laser
  function [2:0] next_mode;
    input [2:0] m;
    input       laser;
    reg   [2:0] n;
    begin
      n = (m == `MODE_LAST) ? `MODE_NORMAL : m + 3'h1;
      if (n == `MODE_BEAM && !laser)
        n = `MODE_DROP;
      next_mode = n;
    end
  endfunction

  // ****************************************
  // Button and timers
  // ****************************************
  button_debounce #(
    .W     (17),
    .LIMIT (DEBOUNCE_CYCLES[16:0])
  ) u_debounce (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (mode_button_i),
    .clean_o (btn)
  );

  cycle_timer #(
    .W     (`TMR_W),
    .LIMIT (HOLD_CYCLES[`TMR_W-1:0])
  ) u_hold (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (!btn),
    .run_i  (btn),
    .done_o (long_hit)
  );

  // Restarted by any press, cleared when the selection ends
  cycle_timer #(
    .W     (`TMR_W),
    .LIMIT (TIMEOUT_CYCLES[`TMR_W-1:0])
  ) u_timeout (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (btn || state_reg != ST_PICK),
    .run_i  (1'b1),
    .done_o (timeout_hit)
  );

  cycle_timer #(
    .W     (`TMR_W),
    .LIMIT (FLASH_CYCLES[`TMR_W-1:0])
  ) u_flash (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (flash_tick),
    .run_i  (1'b1),
    .done_o (flash_tick)
  );

  assign btn_up = !btn && btn_d_reg;

  // ****************************************
  // Mode selection
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg        <= ST_IDLE;
      active_reg       <= `MODE_NORMAL;
      pending_reg      <= `MODE_NORMAL;
      btn_d_reg        <= 1'b0;
      flash_reg        <= 1'b0;
      commit_reg       <= 1'b0;
      timeout_reg      <= 1'b0;
      peer_align_cmd_o <= 1'b0;
    end else begin
      btn_d_reg        <= btn;
      commit_reg       <= 1'b0;
      timeout_reg      <= 1'b0;
      peer_align_cmd_o <= 1'b0;
      if (flash_tick)
        flash_reg <= !flash_reg;
      if (peer_align_req_i && active_reg == `MODE_HAND) begin
        active_reg <= `MODE_ALIGN;
        state_reg  <= ST_IDLE;
        commit_reg <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (btn_up && !long_hit) begin
              pending_reg <= next_mode(active_reg, laser_fit_reg);
              state_reg   <= ST_PICK;
            end
          end
          ST_PICK: begin
            if (long_hit) begin
              state_reg <= ST_HOLD;
            end else if (btn_up) begin
              pending_reg <= next_mode(pending_reg, laser_fit_reg);
            end else if (timeout_hit) begin
              state_reg   <= ST_IDLE;
              timeout_reg <= 1'b1;
            end
          end
          ST_HOLD: begin
            if (btn_up) begin
              active_reg <= pending_reg;
              state_reg  <= ST_IDLE;
              commit_reg <= 1'b1;
              if (pending_reg == `MODE_ALIGN && active_reg == `MODE_HAND && peer_hand_i)
                peer_align_cmd_o <= 1'b1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Indicators and data path gating
  // ****************************************
  always @* begin
    led_next = 5'h00;
    for (i = 0; i < `MODE_COUNT; i = i + 1) begin
      // Beam and drop latch modes run on top of normal transfer
      led_next[i] = (active_reg == i[2:0]) ||
                    (i == 0 && (active_reg == `MODE_BEAM || active_reg == `MODE_DROP));
      if (state_reg == ST_PICK && pending_reg == i[2:0])
        led_next[i] = flash_reg;
      if (state_reg == ST_HOLD)
        led_next[i] = (pending_reg == i[2:0]);
    end
  end

  always @* begin
    tx_next = 1'b1;
    if (active_reg == `MODE_ALIGN)
      tx_next = 1'b0;
    else if (active_reg == `MODE_HAND && rx_level_i < `GREEN_MIN_LEVEL)
      tx_next = 1'b0;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_led_o   <= 5'h01;
      tx_enable_o  <= 1'b1;
      beam_on_o    <= 1'b0;
      drop_red_o   <= 1'b0;
      bar_level_o  <= {`LEVEL_W{1'b0}};
      peer_level_o <= {`LEVEL_W{1'b0}};
    end else begin
      mode_led_o  <= led_next;
      tx_enable_o <= tx_next;
      beam_on_o   <= (active_reg == `MODE_BEAM);
      // A new link loss wins over a re-arm in the same cycle
      if (active_reg == `MODE_DROP && !link_ok_i)
        drop_red_o <= 1'b1;
      else if (rearm || commit_reg || active_reg != `MODE_DROP)
        drop_red_o <= 1'b0;
      if (active_reg == `MODE_ALIGN) begin
        peer_level_o <= rx_level_i;
        bar_level_o  <= peer_level_i;
      end else begin
        peer_level_o <= {`LEVEL_W{1'b0}};
        bar_level_o  <= rx_level_i;
      end
    end
  end

  // ****************************************
  // Wishbone registers and interrupt
  // ****************************************
  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr     = wb_req && wb_we_i && wb_sel_i[0];
  assign rearm     = wb_wr && wb_adr_i == `REG_CTRL && wb_dat_i[`CTRL_REARM_BIT];
  assign irq_clear = (wb_wr && wb_adr_i == `REG_IRQ_CLEAR) ? wb_dat_i[`IRQ_W-1:0]
                                                            : {`IRQ_W{1'b0}};

  // Set wins over a clear arriving in the same cycle
  always @* begin
    irq_status_next = irq_status_reg & ~irq_clear;
    irq_status_next[`IRQ_COMMIT_BIT]  = irq_status_next[`IRQ_COMMIT_BIT] | commit_reg;
    irq_status_next[`IRQ_TIMEOUT_BIT] = irq_status_next[`IRQ_TIMEOUT_BIT] | timeout_reg;
    irq_status_next[`IRQ_DROP_BIT]    = irq_status_next[`IRQ_DROP_BIT] |
                                        (active_reg == `MODE_DROP && !link_ok_i && !drop_red_o);
    irq_status_next[`IRQ_SHUTOFF_BIT] = irq_status_next[`IRQ_SHUTOFF_BIT] |
                                        (tx_enable_o && !tx_next);
    irq_status_next[`IRQ_PEER_BIT]    = irq_status_next[`IRQ_PEER_BIT] |
                                        (peer_align_req_i && active_reg == `MODE_HAND);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h00000000;
      irq_o          <= 1'b0;
      laser_fit_reg  <= `CTRL_RESET;
      irq_status_reg <= {`IRQ_W{1'b0}};
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    end else begin
      wb_ack_o       <= wb_req;
      irq_status_reg <= irq_status_next;
      irq_o          <= |(irq_status_next & irq_enable_reg);
      if (wb_wr && wb_adr_i == `REG_CTRL)
        laser_fit_reg <= wb_dat_i[`CTRL_LASER_BIT];
      if (wb_wr && wb_adr_i == `REG_IRQ_ENABLE)
        irq_enable_reg <= wb_dat_i[`IRQ_W-1:0];
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL:       wb_dat_o <= {31'h00000000, laser_fit_reg};
          `REG_STATUS:     wb_dat_o <= {21'h000000, drop_red_o, tx_enable_o,
                                        state_reg != ST_IDLE, 1'b0, pending_reg,
                                        1'b0, active_reg};
          `REG_IRQ_STATUS: wb_dat_o <= {27'h0000000, irq_status_reg};
          `REG_IRQ_ENABLE: wb_dat_o <= {27'h0000000, irq_enable_reg};
          default:         wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // mode_selector

// ### tb/mode_selector_chk.sv
`timescale 1ns/100ps
// ****************************************
// Port checker
// ****************************************
module mode_selector_chk (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [4:0]  mode_led_o,
  input wire logic        tx_enable_o, beam_on_o, drop_red_o, link_ok_i,
  input wire logic        peer_hand_i, peer_align_cmd_o,
  input wire logic [3:0]  rx_level_i, peer_level_i, peer_level_o, bar_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  reset_vals_a: assert property ($fell(rst_i) |-> mode_led_o == 5'h01 &&
    tx_enable_o && !beam_on_o && !drop_red_o) else $error("bad state after reset");
  tx_fall_a: assert property ($fell(tx_enable_o) |->
    $past(rx_level_i) < 4'h3 || peer_level_o != 4'h0) else $error("tx cut without cause");
  tx_rise_a: assert property ($rose(tx_enable_o) |-> peer_level_o == 4'h0)
    else $error("tx resumed in alignment");
  relay_a: assert property (peer_level_o != 4'h0 |-> peer_level_o == $past(rx_level_i) &&
    bar_level_o == $past(peer_level_i)) else $error("level relay wrong");
  cmd_pulse_a: assert property (peer_align_cmd_o |=> !peer_align_cmd_o)
    else $error("peer command not a pulse");
  cmd_cause_a: assert property (peer_align_cmd_o |-> $past(peer_hand_i))
    else $error("peer command without peer in hand mode");
  red_cause_a: assert property ($rose(drop_red_o) |-> !$past(link_ok_i))
    else $error("red latch without link loss");
  cover property (peer_align_cmd_o);
  cover property ($rose(drop_red_o));
  cover property ($fell(tx_enable_o));
endmodule // mode_selector_chk

bind mode_selector mode_selector_chk i_mode_selector_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .mode_led_o(mode_led_o), .tx_enable_o(tx_enable_o), .beam_on_o(beam_on_o),
  .drop_red_o(drop_red_o), .link_ok_i(link_ok_i), .peer_hand_i(peer_hand_i),
  .peer_align_cmd_o(peer_align_cmd_o), .rx_level_i(rx_level_i),
  .peer_level_i(peer_level_i), .peer_level_o(peer_level_o), .bar_level_o(bar_level_o));

// ### tb/peer_panel.sv
`timescale 1ns/100ps
// ****************************************
// Operator button and opposing unit
// ****************************************
module peer_panel (
  input  wire logic       clk_i,
  output logic            button_o, hand_o, link_o,
  output logic [3:0]      rx_o, lvl_o
);
  initial begin
    button_o = 1'b0;
    hand_o   = 1'b0;
    link_o   = 1'b1;
    rx_o     = 4'h8;
    lvl_o    = 4'h0;
  end
  // Short press advances, long hold commits on release
  task automatic press(input int hold);
    @(posedge clk_i) button_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    button_o <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  // Peer hand-mode state and relayed level
  task automatic link(input logic [3:0] rx, input logic ok, hand, input logic [3:0] lvl);
    @(posedge clk_i);
    rx_o   <= rx;
    link_o <= ok;
    hand_o <= hand;
    lvl_o  <= lvl;
  endtask
endmodule // peer_panel

// ### tb/operating_mode_selector_bench.sv
`timescale 1ns/100ps
// ****************************************
// Bench
// ****************************************
module operating_mode_selector_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [3:0] sel = 4'hF;
  logic wb_ack_o, irq_o, drop_red_o, tx_enable_o, peer_align_cmd_o, btn, hand, lnk, s0, s1;
  logic beam;
  logic [4:0] mode_led_o;
  logic [3:0] bar_level_o, peer_level_o, rx, lvl, rl, pl;
  int n_mismatch = 0, total_checks = 0, n_cmd = 0, seed = 62238;
  initial forever #50 clk_i = ~clk_i;
  peer_panel i_peer_panel (.clk_i(clk_i), .button_o(btn), .hand_o(hand), .link_o(lnk),
    .rx_o(rx), .lvl_o(lvl));
  mode_selector #(.HOLD_CYCLES(40), .TIMEOUT_CYCLES(200), .DEBOUNCE_CYCLES(3),
    .FLASH_CYCLES(8)) i_mode_selector (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .mode_button_i(btn),
    .mode_led_o(mode_led_o), .drop_red_o(drop_red_o), .bar_level_o(bar_level_o),
    .rx_level_i(rx), .link_ok_i(lnk), .tx_enable_o(tx_enable_o), .beam_on_o(beam),
    .peer_hand_i(hand), .peer_align_req_i(req), .peer_level_i(lvl),
    .peer_align_cmd_o(peer_align_cmd_o), .peer_level_o(peer_level_o));
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read notes its expectation with a mask; write sends d
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, m);
    int n = 0;
    @(posedge clk_i);
    if (!w) notes.push_back({m, d});
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= w ? d : 32'h0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (peer_align_cmd_o === 1'b1) n_cmd++;
    if (wb_ack_o === 1'b1 && !we && notes.size() > 0) begin
      note = notes.pop_front();
      chk(wb_dat_o & note[63:32], note[31:0] & note[63:32]);
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h04, 32'h200, 32'h707);
    wb(0, 8'h00, 32'h1, 32'hFFFFFFFF);
    wb(0, 8'h10, 32'h0, 32'hFFFFFFFF);
    wb(0, 8'h20, 32'h0, 32'hFFFFFFFF);
    chk(mode_led_o, 5'h01);
    i_peer_panel.press(8);
    wb(0, 8'h04, 32'h110, 32'h170);
    chk(tx_enable_o, 1'b1);
    {s0, s1} = 2'b00;
    repeat (20) @(posedge clk_i) {s0, s1} = {s0 | !mode_led_o[1], s1 | mode_led_o[1]};
    chk({s0, s1}, 2'b11);
    i_peer_panel.press(8);
    wb(0, 8'h04, 32'h120, 32'h170);
    repeat (250) @(posedge clk_i);
    wb(0, 8'h04, 32'h0, 32'h107);
    wb(0, 8'h08, 32'h2, 32'h2);
    chk(irq_o, 1'b0);
    wb(1, 8'h10, 32'h2, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1, 8'h0C, 32'h2, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    sel <= 4'hE;
    wb(1, 8'h10, 32'h1F, 32'h0);
    sel <= 4'hF;
    wb(0, 8'h10, 32'h2, 32'hFFFFFFFF);
    i_peer_panel.press(8);
    fork
      i_peer_panel.press(60);
      begin
        repeat (50) @(posedge clk_i);
        wb(0, 8'h04, 32'h0, 32'h7);
        chk(mode_led_o, 5'h02);
      end
    join
    wb(0, 8'h04, 32'h1, 32'h7);
    chk(mode_led_o, 5'h02);
    i_peer_panel.link(4'h2, 1'b1, 1'b1, 4'h0);
    repeat (3) @(posedge clk_i);
    chk(tx_enable_o, 1'b0);
    chk(bar_level_o, 4'h2);
    rl = 4'h1 + 4'({$random(seed)} % 15);
    pl = 4'h1 + 4'({$random(seed)} % 15);
    i_peer_panel.link(rl, 1'b1, 1'b1, pl);
    repeat (3) @(posedge clk_i);
    chk(tx_enable_o, rl >= 4'h3);
    i_peer_panel.press(8);
    i_peer_panel.press(60);
    chk(tx_enable_o, 1'b0);
    chk({peer_level_o, bar_level_o}, {rl, pl});
    chk(n_cmd, 1);
    i_peer_panel.press(8);
    i_peer_panel.press(8);
    i_peer_panel.press(60);
    chk(tx_enable_o, 1'b1);
    i_peer_panel.link(rl, 1'b0, 1'b0, pl);
    i_peer_panel.link(rl, 1'b1, 1'b0, pl);
    repeat (2) @(posedge clk_i);
    chk(drop_red_o, 1'b1);
    wb(1, 8'h00, 32'h3, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(drop_red_o, 1'b0);
    i_peer_panel.press(8);
    wb(0, 8'h04, 32'h104, 32'h177);
    repeat (3) i_peer_panel.press(8);
    i_peer_panel.press(60);
    chk(beam, 1'b1);
    chk(mode_led_o, 5'h09);
    chk(tx_enable_o, 1'b1);
    repeat (3) i_peer_panel.press(8);
    i_peer_panel.press(60);
    @(posedge clk_i) req <= 1'b1;
    @(posedge clk_i) req <= 1'b0;
    wb(0, 8'h04, 32'h2, 32'h107);
    wb(0, 8'h08, 32'h1D, 32'h1D);
    wb(1, 8'h00, 32'h0, 32'h0);
    i_peer_panel.press(8);
    wb(0, 8'h04, 32'h142, 32'h177);
    complete_run;
  end
endmodule // operating_mode_selector_bench
